/* logic/rfs_pkg.sv */
// ==========================================================================
// Receive filter and status: shared constants and carriers
// ==========================================================================
package rfs_pkg;

  // ========================================================================
  // Register map
  // ========================================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] FILTER_STATUS_IDX = 8'h02;
  localparam logic [ADDR_W-1:0] FILTER_STATUS_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] LOOPBACK_PERMIT_IDX = 8'h03;
  localparam logic [ADDR_W-1:0] LOOPBACK_PERMIT_ADDR = 8'h0C;
  localparam logic [15:0] FILTER_STATUS_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_MASK = 16'hFE00;
  localparam logic [15:0] CLEAR_ON_START_MASK = 16'h01CF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ========================================================================
  // Field positions in the filter and status register and in the loopback permit register
  // ========================================================================
  localparam int BIT_ACCEPT_ERRORS = 15;
  localparam int BIT_ACCEPT_SHORT = 14;
  localparam int BIT_ACCEPT_BCAST = 13;
  localparam int BIT_PROMISCUOUS = 12;
  localparam int BIT_ALL_MCAST = 11;
  localparam int BIT_LOOPBACK_SEL_HI = 10;
  localparam int BIT_LOOPBACK_SEL_LO = 9;
  localparam int BIT_MULTICAST_SEEN = 8;
  localparam int BIT_BROADCAST_SEEN = 7;
  localparam int BIT_LAST_IN_BUFFER = 6;
  localparam int BIT_CARRIER = 5;
  localparam int BIT_COLLISION = 4;
  localparam int BIT_FCS_ERROR = 3;
  localparam int BIT_ALIGN_ERROR = 2;
  localparam int BIT_LOOPBACK_RX = 1;
  localparam int BIT_RECEIVED_OK = 0;
  localparam int BIT_XCVR_PERMIT = 6;

  // ========================================================================
  // Loopback modes
  // ========================================================================
  typedef enum logic [1:0] {
    RFS_LB_NONE = 2'h0,
    RFS_LB_MAC = 2'h1,
    RFS_LB_CODEC = 2'h2,
    RFS_LB_XCVR = 2'h3
  } rfs_loopback_t;

  // ========================================================================
  // Carriers
  // ========================================================================
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } rfs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfs_axi_rsp_t;

  typedef struct packed {
    logic table_match;
    logic is_multicast;
    logic is_broadcast;
    logic fcs_bad;
    logic misaligned;
    logic short_frame;
    logic collision;
    logic own_loopback;
    logic [15:0] remaining_buffer_words;
    logic [15:0] end_of_buffer_count;
  } rfs_frame_t;

endpackage : rfs_pkg

/* logic/rfs_filter_status.sv */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
module rfs_filter_status (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // Register bus
  input wire rfs_pkg::rfs_axi_req_t axi_req,
  output rfs_pkg::rfs_axi_rsp_t axi_rsp,
  // Receive side
  input wire logic carrier_sense_pin,
  input wire logic rx_start,
  input wire logic rx_end,
  input wire rfs_pkg::rfs_frame_t rx_frame,
  // Results
  output logic rx_accept,
  output logic status_word_valid,
  output logic [15:0] status_word,
  output rfs_pkg::rfs_loopback_t loopback_mode,
  output logic xcvr_loopback_en
);

  // ========================================================================
  // State
  // ========================================================================
  logic [15:0] reg_q;
  logic [15:0] reg_d;
  logic permit_q;
  logic crs_meta_q;
  logic crs_sync_q;
  logic aw_done_q;
  logic w_done_q;
  logic [rfs_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic accept_q;
  logic status_valid_q;
  logic [15:0] status_word_q;
  logic [1:0] lb_mode_q;
  logic xcvr_q;
  logic addr_ok;
  logic error_ok;
  logic length_ok;
  logic accept;
  logic [15:0] new_status;
  logic [15:0] wmask;
  logic do_write;
  logic group_dest;
  logic wr_filter;
  logic wr_permit;

  // ========================================================================
  // Carrier sense synchroniser
  // ========================================================================
  // The pin is asynchronous to ref_clk, so only the second stage feeds logic.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crs_meta_q <= 1'b0;
      crs_sync_q <= 1'b0;
    end else begin
      crs_meta_q <= carrier_sense_pin;
      crs_sync_q <= crs_meta_q;
    end
  end

  // ========================================================================
  // Address filter
  // ========================================================================
  // Broadcast is treated as a subset of multicast, both here and in the status.
  assign group_dest = rx_frame.is_multicast || rx_frame.is_broadcast;

  always_comb begin
    // With no filter bit set only the table match term survives.
    addr_ok = rx_frame.table_match;
    if (reg_q[rfs_pkg::BIT_ACCEPT_BCAST] && rx_frame.is_broadcast) begin
      addr_ok = 1'b1;
    end
    if (reg_q[rfs_pkg::BIT_ALL_MCAST] && group_dest) begin
      addr_ok = 1'b1;
    end
    if (reg_q[rfs_pkg::BIT_PROMISCUOUS] && !group_dest) begin
      addr_ok = 1'b1;
    end
  end

  // ========================================================================
  // Error and length gates
  // ========================================================================
  // Misalignment alone is no error: with a good check sequence the frame stays.
  always_comb begin
    error_ok = reg_q[rfs_pkg::BIT_ACCEPT_ERRORS] || (!rx_frame.fcs_bad && !rx_frame.collision);
    length_ok = !rx_frame.short_frame || reg_q[rfs_pkg::BIT_ACCEPT_SHORT];
    accept = rx_end && addr_ok && error_ok && length_ok;
  end

  // ========================================================================
  // Status for the frame now ending
  // ========================================================================
  always_comb begin
    new_status = 16'h0000;
    new_status[15:9] = reg_q[15:9];
    new_status[rfs_pkg::BIT_CARRIER] = crs_sync_q;
    new_status[rfs_pkg::BIT_MULTICAST_SEEN] = group_dest;
    new_status[rfs_pkg::BIT_BROADCAST_SEEN] = rx_frame.is_broadcast;
    new_status[rfs_pkg::BIT_LAST_IN_BUFFER] =
      rx_frame.remaining_buffer_words <= rx_frame.end_of_buffer_count;
    new_status[rfs_pkg::BIT_COLLISION] = rx_frame.collision;
    new_status[rfs_pkg::BIT_FCS_ERROR] = rx_frame.fcs_bad && !rx_frame.misaligned;
    new_status[rfs_pkg::BIT_ALIGN_ERROR] = rx_frame.fcs_bad && rx_frame.misaligned;
    new_status[rfs_pkg::BIT_LOOPBACK_RX] = rx_frame.own_loopback && !rx_frame.fcs_bad
      && (reg_q[10:9] != 2'h0);
    new_status[rfs_pkg::BIT_RECEIVED_OK] = !rx_frame.fcs_bad && !rx_frame.short_frame
      && !rx_frame.collision;
  end

  // ========================================================================
  // Register bus: write path
  // ========================================================================
  // Address and data may come in either order; the write waits for both.
  assign do_write = aw_done_q && w_done_q && !bvalid_q;
  assign wr_filter = do_write && aw_addr_q == rfs_pkg::FILTER_STATUS_ADDR;
  assign wr_permit = do_write && aw_addr_q == rfs_pkg::LOOPBACK_PERMIT_ADDR;

  always_comb begin
    wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}} & rfs_pkg::CONTROL_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_done_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= '0;
    end else if (awready_q && axi_req.awvalid) begin
      aw_done_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= axi_req.awaddr;
    end else if (do_write) begin
      aw_done_q <= 1'b0;
    end else if (bvalid_q && axi_req.bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      w_done_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wready_q && axi_req.wvalid) begin
      w_done_q <= 1'b1;
      wready_q <= 1'b0;
      w_data_q <= axi_req.wdata;
      w_strb_q <= axi_req.wstrb;
    end else if (do_write) begin
      w_done_q <= 1'b0;
    end else if (bvalid_q && axi_req.bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= rfs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == rfs_pkg::FILTER_STATUS_ADDR || aw_addr_q == rfs_pkg::LOOPBACK_PERMIT_ADDR) begin
        bresp_q <= rfs_pkg::RESP_OKAY;
      end else begin
        bresp_q <= rfs_pkg::RESP_SLVERR;
      end
    end else if (bvalid_q && axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ========================================================================
  // Register bus: read path
  // ========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else if (arready_q && axi_req.arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // The word is sampled at the address handshake; status landing on that
  // same edge shows only on the following read.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= '0;
      rresp_q <= rfs_pkg::RESP_OKAY;
    end else if (arready_q && axi_req.arvalid) begin
      rresp_q <= rfs_pkg::RESP_OKAY;
      if (axi_req.araddr == rfs_pkg::FILTER_STATUS_ADDR) begin
        rdata_q <= {16'h0000, reg_q};
      end else if (axi_req.araddr == rfs_pkg::LOOPBACK_PERMIT_ADDR) begin
        rdata_q <= 32'h00000000;
        rdata_q[rfs_pkg::BIT_XCVR_PERMIT] <= permit_q;
      end else begin
        rdata_q <= 32'h00000000;
        rresp_q <= rfs_pkg::RESP_SLVERR;
      end
    end
  end

  // ========================================================================
  // Filter and status register
  // ========================================================================
  // Software reset is deliberately absent here: only the hardware reset
  // may disturb the filter setup, so a recovering driver keeps its filters.
  always_comb begin
    reg_d = reg_q;
    reg_d[rfs_pkg::BIT_CARRIER] = crs_sync_q;
    if (wr_filter) begin
      reg_d = (reg_d & ~wmask) | (w_data_q[15:0] & wmask);
    end
    if (rx_start) begin
      reg_d = reg_d & ~rfs_pkg::CLEAR_ON_START_MASK;
    end
    // A frame ending in the same cycle as the next start keeps its status.
    if (accept) begin
      reg_d[8:0] = new_status[8:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_q <= rfs_pkg::FILTER_STATUS_RESET;
    end else begin
      reg_q <= reg_d;
    end
  end

  // ========================================================================
  // Transceiver loopback permit
  // ========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      permit_q <= 1'b0;
    end else if (wr_permit && w_strb_q[0]) begin
      permit_q <= w_data_q[rfs_pkg::BIT_XCVR_PERMIT];
    end
  end

  // ========================================================================
  // Packet status word and acceptance strobe
  // ========================================================================
  // The status word carries the filter bits too, so software can tell which
  // filter setting admitted the packet, unless a bus write changes those bits in that same cycle.
  always_ff @(posedge ref_clk) begin
    if (rst || soft_rst) begin
      accept_q <= 1'b0;
      status_valid_q <= 1'b0;
    end else begin
      accept_q <= accept;
      status_valid_q <= accept;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_word_q <= '0;
    end else if (accept) begin
      status_word_q <= {reg_d[15:9], new_status[8:0]};
    end
  end

  // ========================================================================
  // Loopback selection
  // ========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lb_mode_q <= 2'h0;
    end else begin
      lb_mode_q <= reg_q[rfs_pkg::BIT_LOOPBACK_SEL_HI:rfs_pkg::BIT_LOOPBACK_SEL_LO];
    end
  end

  // A cleared permit drops the transceiver loop at once, while the mode
  // output still shows what software asked for.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xcvr_q <= 1'b0;
    end else begin
      xcvr_q <= (reg_q[10:9] == 2'h3) && permit_q;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  always_comb begin
    axi_rsp.awready = awready_q;
    axi_rsp.wready = wready_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = arready_q;
    axi_rsp.rvalid = rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
    rx_accept = accept_q;
    status_word_valid = status_valid_q;
    status_word = status_word_q;
    loopback_mode = rfs_pkg::rfs_loopback_t'(lb_mode_q);
    xcvr_loopback_en = xcvr_q;
  end

endmodule : rfs_filter_status

/* test/rfs_properties.sv */
`timescale 1ns/1ns
// ====================================================================
// Receive filter and status checker
// ====================================================================
module rfs_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // Register bus
  input wire rfs_pkg::rfs_axi_req_t axi_req,
  input wire rfs_pkg::rfs_axi_rsp_t axi_rsp,
  // Receive side
  input wire logic carrier_sense_pin,
  input wire logic rx_start,
  input wire logic rx_end,
  input wire rfs_pkg::rfs_frame_t rx_frame,
  // Results
  input wire logic rx_accept,
  input wire logic status_word_valid,
  input wire logic [15:0] status_word,
  input wire rfs_pkg::rfs_loopback_t loopback_mode,
  input wire logic xcvr_loopback_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_accept_cause: assert property (rx_accept |-> $past(rx_end))
    else $error("accept pulse without packet end");
  a_word_paired: assert property (rx_accept |-> status_word_valid)
    else $error("status word not written with accept");
  a_ok_status: assert property (status_word_valid |->
    status_word[0] == $past(!rx_frame.fcs_bad && !rx_frame.short_frame && !rx_frame.collision))
    else $error("received ok bit wrong");
  a_fcs_align: assert property (status_word_valid |-> status_word[3:2] ==
    $past({rx_frame.fcs_bad & !rx_frame.misaligned, rx_frame.fcs_bad & rx_frame.misaligned}))
    else $error("fcs or alignment bit wrong");
  a_coll_status: assert property (status_word_valid |-> status_word[4] == $past(rx_frame.collision))
    else $error("collision bit wrong");
  a_bcast_status: assert property (status_word_valid |-> status_word[7] == $past(rx_frame.is_broadcast))
    else $error("broadcast seen bit wrong");
  a_error_gate: assert property (status_word_valid && !status_word[15] |-> status_word[4:2] == 3'h0)
    else $error("errored packet accepted");
  a_runt_gate: assert property (status_word_valid && !status_word[14] |-> $past(!rx_frame.short_frame))
    else $error("short packet accepted");
  a_xcvr_mode: assert property (xcvr_loopback_en |-> loopback_mode == rfs_pkg::RFS_LB_XCVR)
    else $error("transceiver loopback in wrong mode");
  a_mcast_status: assert property (status_word_valid |->
    status_word[8] == $past(rx_frame.is_multicast || rx_frame.is_broadcast))
    else $error("multicast seen bit wrong");
  a_last_status: assert property (status_word_valid |->
    status_word[6] == $past(rx_frame.remaining_buffer_words <= rx_frame.end_of_buffer_count))
    else $error("last in buffer bit wrong");
endmodule : rfs_properties

bind rfs_filter_status rfs_properties rfs_properties_i (
  .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .carrier_sense_pin(carrier_sense_pin), .rx_start(rx_start), .rx_end(rx_end), .rx_frame(rx_frame),
  .rx_accept(rx_accept), .status_word_valid(status_word_valid), .status_word(status_word),
  .loopback_mode(loopback_mode), .xcvr_loopback_en(xcvr_loopback_en)
);

/* test/rfs_medium_model.sv */
`timescale 1ns/1ns
// ====================================================================
// Network medium model
// ====================================================================
module rfs_medium_model (
  // Clock
  input wire logic ref_clk,
  // Receive side
  output logic carrier_sense_pin,
  output logic rx_start,
  output logic rx_end,
  output rfs_pkg::rfs_frame_t rx_frame
);
  initial begin
    carrier_sense_pin = 1'b0;
    rx_start = 1'b0;
    rx_end = 1'b0;
    rx_frame = '0;
  end

  // The frame summary is only valid with rx_end, so it is scrambled after.
  task automatic send(input rfs_pkg::rfs_frame_t f, input int gap);
    @(posedge ref_clk);
    carrier_sense_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rx_start <= 1'b1;
    @(posedge ref_clk);
    rx_start <= 1'b0;
    repeat (gap) @(posedge ref_clk);
    rx_end <= 1'b1;
    rx_frame <= f;
    @(posedge ref_clk);
    rx_end <= 1'b0;
    rx_frame <= rfs_pkg::rfs_frame_t'(~f);
    carrier_sense_pin <= 1'b0;
  endtask : send
endmodule : rfs_medium_model

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  rfs_pkg::rfs_axi_req_t req = '0;
  rfs_pkg::rfs_axi_rsp_t rsp;
  rfs_pkg::rfs_frame_t frame;
  rfs_pkg::rfs_loopback_t lb_mode;
  logic carrier_activity, rx_start, rx_end, rx_accept, sw_valid, xcvr_en;
  logic [15:0] status_word, sw_q;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [47:0] row;
  int err_count = 0;
  int compares = 0;
  int acc_n = 0;
  int vld_n = 0;
  int n;
  int v;
  // Columns: control, frame flags, accept, end of buffer, register after.
  logic [47:0] rows [14] = '{
    48'h0000_20_00_0000, 48'h0000_80_10_0001, 48'h2000_60_10_2181, 48'h0800_60_10_0981,
    48'h0800_40_10_0901, 48'h1000_00_10_1001, 48'h0000_90_00_0000, 48'h8000_98_10_8004,
    48'h8000_92_10_8018, 48'h0000_84_00_0010, 48'h4000_84_10_4000, 48'h0000_88_10_0001,
    48'h0000_80_11_0041, 48'h0200_81_10_0203};

  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (rx_accept === 1'b1) begin
      acc_n <= acc_n + 1;
      sw_q <= status_word;
    end
    if (sw_valid === 1'b1) vld_n <= vld_n + 1;
  end

  rfs_filter_status rfs_filter_status_i (
    .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .axi_req(req), .axi_rsp(rsp),
    .carrier_sense_pin(carrier_activity), .rx_start(rx_start), .rx_end(rx_end), .rx_frame(frame),
    .rx_accept(rx_accept), .status_word_valid(sw_valid), .status_word(status_word),
    .loopback_mode(lb_mode), .xcvr_loopback_en(xcvr_en));

  rfs_medium_model rfs_medium_model_i (
    .ref_clk(ref_clk), .carrier_sense_pin(carrier_activity), .rx_start(rx_start), .rx_end(rx_end), .rx_frame(frame));

  // ====================================================================
  // Check, bus and end of test tasks
  // ====================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd_reg

  task automatic end_of_test();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ====================================================================
  // Tests
  // ====================================================================
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(rfs_pkg::FILTER_STATUS_ADDR);
    chk(rd, 32'h0000_0000);
    wr(rfs_pkg::FILTER_STATUS_ADDR, 32'hFFFF_FFFF);
    rd_reg(rfs_pkg::FILTER_STATUS_ADDR);
    chk(rd, 32'h0000_FE00);
    @(posedge ref_clk);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    rd_reg(rfs_pkg::FILTER_STATUS_ADDR);
    chk(rd, 32'h0000_FE00);
    wr(8'h10, 32'h0000_1234);
    chk({30'h0, resp}, {30'h0, rfs_pkg::RESP_SLVERR});
    rd_reg(8'h10);
    chk({rd[31:2], resp}, {30'h0, rfs_pkg::RESP_SLVERR});
    for (int m = 0; m < 4; m++) begin
      wr(rfs_pkg::FILTER_STATUS_ADDR, 32'(m) << 9);
      repeat (2) @(posedge ref_clk);
      chk({29'h0, xcvr_en, lb_mode}, 32'(m));
    end
    wr(rfs_pkg::LOOPBACK_PERMIT_ADDR, 32'h0000_0040);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, xcvr_en}, 32'h1);
    for (int i = 0; i < 14; i++) begin
      row = rows[i];
      wr(rfs_pkg::FILTER_STATUS_ADDR, {16'h0, row[47:32]});
      n = acc_n;
      v = vld_n;
      rfs_medium_model_i.send(rfs_pkg::rfs_frame_t'({row[31:24],
        (row[19:16] != 4'h0) ? 16'h0004 : 16'h0010, 16'h0004}), i % 3);
      repeat (4) @(posedge ref_clk);
      chk(32'(acc_n - n), {28'h0, row[23:20]});
      chk(32'(vld_n - v), {28'h0, row[23:20]});
      if (row[23:20] != 4'h0) chk({16'h0, sw_q}, {16'h0, row[15:0] | 16'h0020});
      rd_reg(rfs_pkg::FILTER_STATUS_ADDR);
      chk(rd, {16'h0, row[15:0]});
    end
    end_of_test();
  end
endmodule : tb_top
